// [design/asid_pkg.sv]
// Package for the area select input decoder: register map, field layout,
// reset values and timing constants.
// Assumes a 50 MHz core clock and a 32-bit Avalon-MM register port.
package asid_pkg;

    // ------------------------------------------------------------------
    // Geometry of the selection inputs
    // ------------------------------------------------------------------
    localparam int NUM_PAIRS = 5;
    localparam int PAIR_W = 3;
    localparam int AREA_W = 8;
    localparam int COUNT_W = 4;
    localparam logic [AREA_W-1:0] MAX_FIXED_AREA = 8'h80;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_DELAY = 5'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_PAIRS_LSB = 4;
    localparam int DELAY_W = 16;
    localparam int STAT_AREA_LSB = 0;
    localparam int STAT_VALID_BIT = 8;
    localparam int STAT_ERR_BIT = 9;
    localparam int STAT_SETTLING_BIT = 10;
    localparam int STAT_TRUE_LSB = 16;
    localparam int STAT_COMP_LSB = 24;
    localparam int IRQ_W = 2;
    localparam int IRQ_AREA_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;

    // ------------------------------------------------------------------
    // Mode encodings and reset values
    // ------------------------------------------------------------------
    localparam logic MODE_PAIR = 1'b0;
    localparam logic MODE_FIXED = 1'b1;
    localparam logic [PAIR_W-1:0] PAIRS_RESET = 3'h5;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int MS_PER_S = 1000;
    localparam int SETTLE_DEFAULT_MS = 30;
    localparam logic [DELAY_W-1:0] DELAY_RESET = DELAY_W'(SETTLE_DEFAULT_MS);
    localparam int TICK_W = 17;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_HOLD = 2'b10
    } asid_state_t;

endpackage

// [design/asid_sync2.sv]
// Two-stage synchroniser for a group of static input lines.
// Assumes the lines change slowly compared with the core clock.
`timescale 1ns/1ps
`default_nettype none
module asid_sync2 #(
    parameter int W = 5
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] metaR;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            metaR <= '0;
            syncOut <= '0;
        end else begin
            metaR <= asyncIn;
            syncOut <= metaR;
        end
    end
endmodule
`default_nettype wire

// [design/asid_fixed_rank.sv]
// Ranks an ON pattern of the used lines for fixed-count selection.
// Used lines are the true lines of the configured pairs, then their complements.
// Assumes the caller checks that the ON count is half the used lines.
`timescale 1ns/1ps
`default_nettype none
module asid_fixed_rank
    import asid_pkg::*;
(
    input wire logic [asid_pkg::NUM_PAIRS-1:0] trueIn,
    input wire logic [asid_pkg::NUM_PAIRS-1:0] compIn,
    input wire logic [asid_pkg::PAIR_W-1:0] pairs,
    output logic [asid_pkg::AREA_W-1:0] rank,
    output logic [asid_pkg::COUNT_W-1:0] onCount
);
    function automatic int binom(input int n, input int k);
        int p[0:9][0:5];
        for (int i = 0; i < 10; i++) begin
            for (int j = 0; j < 6; j++) begin
                if (j == 0) p[i][j] = 1;
                else if (i == 0) p[i][j] = 0;
                else p[i][j] = p[i-1][j-1] + p[i-1][j];
            end
        end
        return (k > 5) ? 0 : p[n][k];
    endfunction

    // Colex rank: the pattern table therefore depends on the used line count.
    always_comb begin
        logic [2*NUM_PAIRS-1:0] vec;
        int cnt;
        int acc;
        int np;
        vec = '0;
        cnt = 0;
        acc = 0;
        np = int'(pairs);
        for (int i = 0; i < 2 * NUM_PAIRS; i++) begin
            if (i < np) vec[i] = trueIn[i];
            else if (i < 2 * np) vec[i] = compIn[i-np];
        end
        for (int i = 0; i < 2 * NUM_PAIRS; i++) begin
            if (vec[i]) begin
                cnt = cnt + 1;
                acc = acc + binom(i, cnt);
            end
        end
        rank = AREA_W'(acc);
        onCount = COUNT_W'(cnt);
    end
endmodule
`default_nettype wire

// [design/asid_decoder.sv]
// Area select input decoder: settles, checks and decodes the external
// area selection lines into the active area number.
// Assumes static lines from an external controller and an Avalon-MM master.
`timescale 1ns/1ps
`default_nettype none

module asid_decoder
    import asid_pkg::*;
#(
    parameter int TICK_CYCLES = asid_pkg::CLK_FREQ_HZ / asid_pkg::MS_PER_S
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [asid_pkg::NUM_PAIRS-1:0] trueLine,
    input wire logic [asid_pkg::NUM_PAIRS-1:0] compLine,
    input wire logic [asid_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [asid_pkg::AREA_W-1:0] areaNum,
    output logic areaValid,
    output logic inputError,
    output logic irq
);
    import asid_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [NUM_PAIRS-1:0] trueSync;
    logic [NUM_PAIRS-1:0] compSync;

    asid_sync2 #(.W(NUM_PAIRS)) u_syncTrue (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(trueLine),
        .syncOut(trueSync)
    );

    asid_sync2 #(.W(NUM_PAIRS)) u_syncComp (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(compLine),
        .syncOut(compSync)
    );

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic modeR;
    logic [PAIR_W-1:0] pairsR;
    logic [DELAY_W-1:0] delayR;
    logic [IRQ_W-1:0] irqStatR;
    logic [IRQ_W-1:0] irqStatNxt;
    logic [IRQ_W-1:0] irqMaskR;
    logic ackR;
    logic [31:0] readDataR;
    logic [NUM_PAIRS-1:0] trueSeenR;
    logic [NUM_PAIRS-1:0] compSeenR;
    logic [TICK_W-1:0] tickCntR;
    logic [DELAY_W-1:0] msCntR;
    logic [AREA_W-1:0] areaR;
    logic validR;
    logic errR;
    asid_state_t stateR;
    asid_state_t stateNxt;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire busReq = avs_read | avs_write;
    wire wrAck = avs_write & ackR;
    wire rdLoad = avs_read & ~ackR;
    wire selCtrl = (avs_address == REG_CTRL);
    wire selDelay = (avs_address == REG_DELAY);
    wire selStatus = (avs_address == REG_STATUS);
    wire selIrqStat = (avs_address == REG_IRQ_STAT);
    wire selIrqMask = (avs_address == REG_IRQ_MASK);
    wire [31:0] laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wrBits = avs_writedata & laneMask;
    wire ctrlWr = wrAck & selCtrl & avs_byteenable[0];
    wire delayWr = wrAck & selDelay;
    wire irqClrWr = wrAck & selIrqStat;
    wire irqMaskWr = wrAck & selIrqMask;

    // One wait state on every access; unmapped addresses read zero.
    assign avs_waitrequest = busReq & ~ackR;
    assign avs_readdata = readDataR;

    wire [31:0] ctrlView = {25'h0, pairsR, 3'h0, modeR};
    wire [31:0] delayView = {16'h0, delayR};
    wire [31:0] statusView = {3'h0, compSync, 3'h0, trueSync, 5'h00,
                              (stateR == ST_SETTLE), errR, validR, areaR};
    wire [31:0] irqStatView = {30'h0, irqStatR};
    wire [31:0] irqMaskView = {30'h0, irqMaskR};
    wire [31:0] rdMux = selCtrl ? ctrlView :
                        selDelay ? delayView :
                        selStatus ? statusView :
                        selIrqStat ? irqStatView :
                        selIrqMask ? irqMaskView : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire [NUM_PAIRS-1:0] pairUsed;
    wire [NUM_PAIRS-1:0] pairBad;
    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++) begin : gPair
            assign pairUsed[g] = (PAIR_W'(g) < pairsR);
            assign pairBad[g] = pairUsed[g] & (trueSync[g] == compSync[g]);
        end
    endgenerate

    wire pairsCfgOk = (pairsR != 3'h0) && (pairsR <= PAIR_W'(NUM_PAIRS));
    // Area minus one carries a one in bit k when pair k is used and its complement is ON.
    wire [AREA_W-1:0] pairCode = {{(AREA_W - NUM_PAIRS){1'b0}}, compSync & pairUsed};
    wire [AREA_W-1:0] pairArea = pairCode + 8'h01;
    wire pairOk = pairsCfgOk & ~(|pairBad);

    logic [AREA_W-1:0] fixedRank;
    logic [COUNT_W-1:0] fixedOn;

    asid_fixed_rank u_rank (
        .trueIn(trueSync),
        .compIn(compSync),
        .pairs(pairsR),
        .rank(fixedRank),
        .onCount(fixedOn)
    );

    // Ranking from the used set alone lets the line count shape the table.
    wire [AREA_W-1:0] fixedArea = fixedRank + 8'h01;
    // Half the used lines equals the pair count; with two pairs, any two ON.
    wire fixedCountOk = (fixedOn == COUNT_W'(pairsR));
    wire fixedOk = pairsCfgOk & fixedCountOk & (fixedArea <= MAX_FIXED_AREA);

    wire decOk = (modeR == MODE_FIXED) ? fixedOk : pairOk;
    wire [AREA_W-1:0] decArea = (modeR == MODE_FIXED) ? fixedArea : pairArea;

    // ------------------------------------------------------------------
    // Settling timer
    // ------------------------------------------------------------------
    // Any edge on the lines or a new setup restarts the full delay.
    wire linesMoved = (trueSync != trueSeenR) | (compSync != compSeenR);
    wire restart = linesMoved | ctrlWr | delayWr;
    wire msTick = (tickCntR == TICK_W'(TICK_CYCLES - 1));
    wire settled = (stateR == ST_SETTLE) & ~restart & (msCntR >= delayR);
    wire areaChanged = settled & decOk & (~validR | (areaR != decArea));
    wire errEvent = settled & ~decOk;

    always_comb begin
        case (stateR)
            ST_SETTLE: stateNxt = settled ? ST_HOLD : ST_SETTLE;
            ST_HOLD: stateNxt = restart ? ST_SETTLE : ST_HOLD;
            default: stateNxt = ST_SETTLE;
        endcase
    end

    // A new event wins over a clear written in the same cycle.
    assign irqStatNxt = (irqStatR & ~(irqClrWr ? wrBits[IRQ_W-1:0] : 2'h0)) | {errEvent, areaChanged};

    // ------------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackR <= 1'b0;
            readDataR <= 32'h0000_0000;
        end else begin
            ackR <= busReq & ~ackR;
            if (rdLoad) begin
                readDataR <= rdMux;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modeR <= MODE_PAIR;
            pairsR <= PAIRS_RESET;
            delayR <= DELAY_RESET;
            irqMaskR <= IRQ_MASK_RESET;
        end else begin
            if (ctrlWr) begin
                modeR <= wrBits[CTRL_MODE_BIT];
                pairsR <= wrBits[CTRL_PAIRS_LSB +: PAIR_W];
            end
            if (delayWr) begin
                delayR <= (delayR & ~laneMask[DELAY_W-1:0]) | wrBits[DELAY_W-1:0];
            end
            if (irqMaskWr & avs_byteenable[0]) begin
                irqMaskR <= wrBits[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStatR <= '0;
        end else begin
            irqStatR <= irqStatNxt;
        end
    end

    // ------------------------------------------------------------------
    // Settling and area registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateR <= ST_SETTLE;
            trueSeenR <= '0;
            compSeenR <= '0;
            tickCntR <= '0;
            msCntR <= '0;
        end else begin
            stateR <= stateNxt;
            trueSeenR <= trueSync;
            compSeenR <= compSync;
            if (restart | msTick) begin
                tickCntR <= '0;
            end else begin
                tickCntR <= tickCntR + TICK_W'(1);
            end
            if (restart) begin
                msCntR <= '0;
            end else if (msTick & (msCntR != {DELAY_W{1'b1}})) begin
                msCntR <= msCntR + DELAY_W'(1);
            end
        end
    end

    // The old area stays in force while new inputs settle, so a moving
    // input never shows a half-switched area.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            areaR <= '0;
            validR <= 1'b0;
            errR <= 1'b0;
        end else if (settled) begin
            errR <= ~decOk;
            validR <= decOk;
            if (decOk) begin
                areaR <= decArea;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign areaNum = areaR;
    assign areaValid = validR;
    assign inputError = errR;
    assign irq = |(irqStatR & irqMaskR);

endmodule
`default_nettype wire

// [bench/asid_decoder_checker.sv]
// Port assertions for the area select input decoder, bound to its top module.
// Assumes every register write enables the byte lanes of the fields it changes.
`timescale 1ns/1ps
`default_nettype none
module asid_decoder_checker
    import asid_pkg::*;
#(
    parameter int TICK_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [asid_pkg::NUM_PAIRS-1:0] trueLine,
    input wire logic [asid_pkg::NUM_PAIRS-1:0] compLine,
    input wire logic [asid_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [asid_pkg::AREA_W-1:0] areaNum,
    input wire logic areaValid,
    input wire logic inputError,
    input wire logic irq
);
    logic mode_r;
    logic [PAIR_W-1:0] pairs_r;
    logic [DELAY_W-1:0] delay_r;
    logic [IRQ_W-1:0] mask_r;
    logic [9:0] lines_r;
    int stable_r;
    wire logic wrDone = avs_write && !avs_waitrequest;
    wire logic [NUM_PAIRS-1:0] useMask = NUM_PAIRS'((6'h01 << pairs_r) - 6'h01);
    wire logic [NUM_PAIRS-1:0] diffUsed = (trueLine ^ compLine) & useMask;
    wire logic [3:0] onUsed = 4'($countones({trueLine & useMask, compLine & useMask}));
    // Register copies are snooped from the bus so the checker needs no internal probes.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_PAIR;
            pairs_r <= PAIRS_RESET;
            delay_r <= DELAY_RESET;
            mask_r <= IRQ_MASK_RESET;
            lines_r <= '0;
            stable_r <= 0;
        end else begin
            lines_r <= {trueLine, compLine};
            stable_r <= ({trueLine, compLine} != lines_r) ? 0 : stable_r + 1;
            if (wrDone && avs_address == REG_CTRL && avs_byteenable[0]) begin
                mode_r <= avs_writedata[CTRL_MODE_BIT];
                pairs_r <= avs_writedata[CTRL_PAIRS_LSB +: PAIR_W];
            end
            if (wrDone && avs_address == REG_DELAY && avs_byteenable[1:0] == 2'h3) begin
                delay_r <= avs_writedata[DELAY_W-1:0];
            end
            if (wrDone && avs_address == REG_IRQ_MASK && avs_byteenable[0]) begin
                mask_r <= avs_writedata[IRQ_W-1:0];
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_SETTLE: assert property (($changed(areaNum) || $rose(areaValid) || $rose(inputError))
        |-> stable_r >= int'(delay_r) * TICK_CYCLES) else $error("selection accepted before settling");
    AST_PAIR_AREA: assert property (mode_r == MODE_PAIR && areaValid && ($changed(areaNum) || $rose(areaValid))
        |-> areaNum == AREA_W'(compLine & useMask) + 8'h01) else $error("wrong pair area");
    AST_PAIR_COMPL: assert property (mode_r == MODE_PAIR && $rose(areaValid) |-> diffUsed == useMask)
        else $error("valid area from non complementary pairs");
    AST_PAIR_ERR: assert property (mode_r == MODE_PAIR && $rose(inputError) |-> diffUsed != useMask)
        else $error("error flagged on good pairs");
    AST_FIXED_HALF: assert property (mode_r == MODE_FIXED && $rose(areaValid) |-> onUsed == 4'(pairs_r))
        else $error("fixed area accepted with wrong on count");
    AST_ERR_NOVALID: assert property (inputError |-> !areaValid) else $error("error and valid together");
    AST_ERR_KEEP: assert property ($rose(inputError) |-> $stable(areaNum)) else $error("area changed on error");
    AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state on new request");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state too long");
    AST_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
    AST_IRQ_MASK: assert property (irq |-> mask_r != '0) else $error("interrupt while fully masked");
endmodule
bind asid_decoder asid_decoder_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.core_clk, .rst_n, .trueLine,
    .compLine, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
    .areaNum, .areaValid, .inputError, .irq);
`default_nettype wire

// [bench/asid_ctrl_model.sv]
// Model of the machine controller that drives the area selection lines.
// Assumes the bench names a pair code or a fixed-mode line pattern and changes it only between selections.
`timescale 1ns/1ps
`default_nettype none
module asid_ctrl_model
    import asid_pkg::*;
(
    input wire logic core_clk,
    input wire logic fixedSel,
    input wire logic [asid_pkg::PAIR_W-1:0] pairs,
    input wire logic [9:0] code,
    input wire logic breakRule,
    output logic [asid_pkg::NUM_PAIRS-1:0] trueLine,
    output logic [asid_pkg::NUM_PAIRS-1:0] compLine
);
    wire logic [NUM_PAIRS-1:0] useMask = NUM_PAIRS'((6'h01 << pairs) - 6'h01);
    wire logic [NUM_PAIRS-1:0] compBits = (fixedSel ? NUM_PAIRS'(code >> pairs) : code[NUM_PAIRS-1:0]) & useMask;
    wire logic [NUM_PAIRS-1:0] trueBits = (fixedSel ? code[NUM_PAIRS-1:0] : ~compBits) & useMask;
    initial begin
        trueLine = '1;
        compLine = '1;
    end
    // Unused lines sit both ON, a pattern the decoder must ignore.
    always @(posedge core_clk) begin
        trueLine <= trueBits | ~useMask;
        compLine <= (compBits ^ NUM_PAIRS'(breakRule)) | ~useMask;
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the area select input decoder.
// Assumes an Avalon-MM master at the register port and a shortened millisecond tick.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import asid_pkg::*;
    localparam int TICK = 4;
    localparam int DLY = 3;
    typedef struct packed {logic fx; logic [2:0] np; logic [9:0] code; logic brk; logic [7:0] area; logic err;} asid_row_t;
    logic core_clk = 1'b0;
    logic rst_n;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, areaValid, inputError, irq;
    logic [31:0] avs_writedata, avs_readdata;
    logic [AREA_W-1:0] areaNum;
    logic [NUM_PAIRS-1:0] trueLine, compLine;
    logic modelFixed, modelBreak;
    logic [PAIR_W-1:0] modelPairs;
    logic [9:0] modelCode;
    int err_count = 0;
    int cmp_count = 0;
    asid_row_t rows [16] = '{
        '{1'h0, 3'h5, 10'h000, 1'h0, 8'h01, 1'h0}, '{1'h0, 3'h5, 10'h01F, 1'h0, 8'h20, 1'h0},
        '{1'h0, 3'h5, 10'h010, 1'h0, 8'h11, 1'h0}, '{1'h0, 3'h5, 10'h010, 1'h1, 8'h11, 1'h1},
        '{1'h0, 3'h4, 10'h00F, 1'h0, 8'h10, 1'h0}, '{1'h0, 3'h3, 10'h007, 1'h0, 8'h08, 1'h0},
        '{1'h0, 3'h3, 10'h004, 1'h0, 8'h05, 1'h0}, '{1'h0, 3'h2, 10'h002, 1'h0, 8'h03, 1'h0},
        '{1'h0, 3'h1, 10'h000, 1'h0, 8'h01, 1'h0}, '{1'h0, 3'h1, 10'h001, 1'h0, 8'h02, 1'h0},
        '{1'h1, 3'h2, 10'h003, 1'h0, 8'h01, 1'h0}, '{1'h1, 3'h2, 10'h005, 1'h0, 8'h02, 1'h0},
        '{1'h1, 3'h2, 10'h00A, 1'h0, 8'h05, 1'h0}, '{1'h1, 3'h2, 10'h006, 1'h0, 8'h03, 1'h0},
        '{1'h1, 3'h2, 10'h006, 1'h1, 8'h03, 1'h1}, '{1'h1, 3'h3, 10'h00B, 1'h0, 8'h02, 1'h0}};
    always #10 core_clk = ~core_clk;
    asid_decoder #(.TICK_CYCLES(TICK)) dut (.core_clk(core_clk), .rst_n(rst_n), .trueLine(trueLine),
        .compLine(compLine), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .areaNum(areaNum), .areaValid(areaValid),
        .inputError(inputError), .irq(irq));
    asid_ctrl_model ctrl (.core_clk(core_clk), .fixedSel(modelFixed), .pairs(modelPairs), .code(modelCode),
        .breakRule(modelBreak), .trueLine(trueLine), .compLine(compLine));
    task automatic report_and_stop();
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Waitrequest and read data are taken at the rising edge itself, before that edge's updates land.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic w;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            w = avs_waitrequest;
            q = avs_readdata;
            n++;
        end while (w !== 1'b0 && n < 50);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic settle(input asid_row_t r);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!(r.err ? inputError === 1'b1 && areaValid === 1'b0 :
            areaValid === 1'b1 && inputError === 1'b0 && areaNum === r.area) && n < 400);
        if (n >= 400) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
        chk(32'(areaNum), 32'(r.area));
        chk(32'(n >= DLY * TICK), 32'h1);
        chk(32'(irq), 32'h0);
        @(posedge core_clk);
    endtask
    initial begin
        rst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        modelFixed = 1'b0;
        modelPairs = PAIRS_RESET;
        modelCode = 10'h015;
        modelBreak = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk(32'({areaNum, areaValid, inputError, irq}), 32'h0);
        rd(REG_CTRL, 32'h00000050);
        rd(REG_DELAY, 32'h0000001E);
        rd(REG_IRQ_MASK, 32'h0);
        rd(5'h14, 32'h0);
        wr(REG_DELAY, 32'(DLY));
        foreach (rows[i]) begin
            if (rows[i].fx !== modelFixed || rows[i].np !== modelPairs) begin
                wr(REG_CTRL, 32'({rows[i].np, 3'h0, rows[i].fx}));
            end
            modelFixed <= rows[i].fx;
            modelPairs <= rows[i].np;
            modelCode <= rows[i].code;
            modelBreak <= rows[i].brk;
            settle(rows[i]);
        end
        // A disturbance shorter than the settling delay must never be accepted.
        modelBreak <= 1'b1;
        repeat (DLY * TICK - 4) @(posedge core_clk);
        modelBreak <= 1'b0;
        repeat (3 * DLY * TICK) @(posedge core_clk);
        chk(32'({areaNum, areaValid, inputError}), 32'h00A);
        rd(REG_STATUS, 32'h191B0102);
        rd(REG_IRQ_STAT, 32'h3);
        wr(REG_IRQ_MASK, 32'h2);
        chk(32'(irq), 32'h1);
        wr(REG_IRQ_STAT, 32'h2);
        chk(32'(irq), 32'h0);
        rd(REG_IRQ_STAT, 32'h1);
        wr(REG_IRQ_MASK, 32'h3);
        chk(32'(irq), 32'h1);
        wr(REG_IRQ_STAT, 32'h1);
        chk(32'(irq), 32'h0);
        wr(5'h1C, 32'hFFFFFFFF);
        rd(REG_IRQ_MASK, 32'h3);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(32'({areaNum, areaValid, inputError, irq}), 32'h0);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(REG_CTRL, 32'h00000050);
        report_and_stop();
    end
endmodule
`default_nettype wire
